// file: rsc_pkg.sv
// package: constants and types for the remote status, calibration request and terminal line editor block
// assumes one 40 MHz clock, an apb master for registers and a byte-wide serial link outside
package rsc_pkg;

  // ==========================================================================
  // apb register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_CMD_ACK   = 8'h08;
  localparam logic [7:0] ADDR_TXDATA    = 8'h0C;
  localparam logic [7:0] ADDR_LINE_BASE = 8'h10;
  localparam logic [7:0] ADDR_LINE_LAST = 8'h2C;

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int         CTRL_W         = 9;
  localparam int         CTRL_FAULT     = 0;
  localparam int         CTRL_VALID     = 1;
  localparam int         CTRL_AUTO      = 2;
  localparam int         CTRL_UPPER     = 3;
  localparam int         CTRL_DIAG      = 4;
  localparam int         CTRL_CAL_LSB   = 5;
  localparam int         CTRL_FLAG1     = 7;
  localparam int         CTRL_FLAG2     = 8;
  localparam logic [8:0] CTRL_RESET     = 9'h000;

  // ==========================================================================
  // status register fields, status output bits, txdata fields
  // ==========================================================================
  localparam int ST_CAL_LSB  = 0;
  localparam int ST_REMOTE   = 2;
  localparam int ST_INTER    = 3;
  localparam int ST_LIST_RUN = 4;
  localparam int ST_LIST_PS  = 5;
  localparam int ST_CMD_PEND = 6;
  localparam int ST_SW_BUSY  = 7;
  localparam int ST_LEN_LSB  = 8;
  localparam int OUT_HEALTHY = 0;
  localparam int OUT_VALID   = 1;
  localparam int OUT_UPPER   = 2;
  localparam int OUT_ZERO    = 3;
  localparam int OUT_SPAN    = 4;
  localparam int OUT_SERVICE = 5;
  localparam int OUT_LOWER   = 6;
  localparam int OUT_SPARE   = 7;
  localparam int TX_EOM_BIT  = 8;

  // ==========================================================================
  // remote inputs, line buffer, characters
  // ==========================================================================
  localparam int         REQ_ZERO    = 0;
  localparam int         REQ_SPAN    = 1;
  localparam int         REQ_MID     = 2;
  localparam logic [1:0] DEB_LAST    = 2'h3;
  localparam logic [5:0] LINE_MAX    = 6'h20;
  localparam logic [7:0] CH_CTRL_C   = 8'h03;
  localparam logic [7:0] CH_CTRL_P   = 8'h10;
  localparam logic [7:0] CH_CTRL_T   = 8'h14;
  localparam logic [7:0] CH_BS       = 8'h08;
  localparam logic [7:0] CH_CR       = 8'h0D;
  localparam logic [7:0] CH_LF       = 8'h0A;
  localparam logic [7:0] CH_ESC      = 8'h1B;
  localparam logic [7:0] CH_SPACE    = 8'h20;
  localparam logic [7:0] CH_QUERY    = 8'h3F;
  localparam logic [7:0] CH_TILDE    = 8'h7E;
  localparam logic [7:0] CH_LOW_A    = 8'h61;
  localparam logic [7:0] CH_LOW_Z    = 8'h7A;
  localparam logic [7:0] CASE_OFFSET = 8'h20;

  // help listing text, every line ends in cr lf
  localparam int         HELP_LEN  = 69;
  localparam logic [6:0] HELP_LAST = 7'h44;
  localparam logic [8*HELP_LEN-1:0] HELP_TEXT =
    "C CALIBRATION\015\012D DIAGNOSTIC\015\012L LOGON\015\012T TEST\015\012V VARIABLE\015\012W WARNING\015\012";

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {CAL_NONE, CAL_ZERO, CAL_SPAN, CAL_MID} rsc_cal_t;
  typedef enum logic {TM_COMPUTER, TM_INTERACTIVE} rsc_term_t;
  typedef enum logic [1:0] {LS_IDLE, LS_RUN, LS_PAUSED} rsc_list_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rsc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rsc_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rsc_byte_t;

endpackage

// file: rsc_remote_ctrl.sv
// module: status outputs, debounced remote calibration requests and a serial terminal front end
// assumes inputs synchronous to i_clk except the remote requests; apb slave with no wait states
//
// Overview of operation
// - healthy output on exactly when no fault
// - valid output follows measurement validity
// - auto scale: upper output when upper used
// - auto scale: lower output when lower used
// - baseline output while in zero calibration
// - full-scale output while in upscale calibration
// - service output while in diagnostic mode
// - remote baseline request enters zero calibration
// - remote full-scale request enters upscale calibration
// - remote midpoint request enters midpoint calibration
// - control-T selects interactive echoing editing mode
// - interactive only while flags one, two clear
// - control-C outside listing selects silent computer mode
// - command runs only after carriage return
// - backspace removes last entered character
// - escape discards whole pending line
// - question mark command sends command listing
// - control-C halts running listing
// - control-P resumes halted listing where stopped
// - case folded, arguments separated by space
// - every message ends with cr lf
`timescale 1ns/1ps
module rsc_remote_ctrl
  import rsc_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire rsc_apb_req_t i_apb,
  output rsc_apb_rsp_t      o_apb,
  input  wire logic [2:0]   i_remote_req,
  input  wire logic [2:0]   i_remote_spare,
  output logic [7:0]        o_status,
  output logic              o_remote_zero_indication,
  output logic              o_remote_span_indication,
  output logic              o_remote_midpoint_indication,
  input  wire rsc_byte_t    i_rx,
  output rsc_byte_t         o_tx,
  input  wire logic         i_tx_ready
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [2:0]                sync1;
    logic [2:0]                sync2;
    logic [2:0]                level;
    logic [2:0][1:0]           deb_cnt;
    rsc_cal_t                  cal;
    logic                      remote;
    logic [2:0]                remote_ind;
    logic [7:0]                status;
    logic [CTRL_W-1:0]         ctrl;
    rsc_term_t                 term;
    rsc_list_t                 list;
    logic [6:0]                help_idx;
    logic [31:0][7:0]          line;
    logic [5:0]                len;
    logic                      cmd_pend;
    logic [7:0]                echo_byte;
    logic                      echo_pend;
    logic [7:0]                sw_byte;
    logic                      sw_pend;
    logic                      sw_eom;
    logic                      pend_cr;
    logic                      pend_lf;
    rsc_byte_t                 tx;
    rsc_apb_rsp_t              apb;
  } rsc_state_t;

  rsc_state_t s_r;
  rsc_state_t s_nxt;

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a <= ADDR_LINE_LAST);
  endfunction

  function automatic logic [7:0] to_upper(input logic [7:0] b);
    to_upper = ((b >= CH_LOW_A) && (b <= CH_LOW_Z)) ? (b - CASE_OFFSET) : b;
  endfunction

  function automatic logic is_printable(input logic [7:0] b);
    is_printable = (b >= CH_SPACE) && (b <= CH_TILDE);
  endfunction

  function automatic logic [7:0] help_byte(input logic [6:0] idx);
    help_byte = HELP_TEXT[8*(HELP_LEN-1-int'(idx)) +: 8];
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic        flags_set;
    logic [31:0] rd;
    logic [7:0]  b;
    logic [7:0]  woff;
    flags_set = 1'b0;
    rd        = '0;
    b         = '0;
    woff      = '0;
    s_nxt     = s_r;

    // remote request synchroniser and debounce; spare inputs are not read
    s_nxt.sync1 = i_remote_req;
    s_nxt.sync2 = s_r.sync1;
    for (int k = 0; k < 3; k++) begin
      if (s_r.sync2[k] == s_r.level[k]) begin
        s_nxt.deb_cnt[k] = 2'h0;
      end else if (s_r.deb_cnt[k] == DEB_LAST) begin
        s_nxt.level[k]   = s_r.sync2[k];
        s_nxt.deb_cnt[k] = 2'h0;
      end else begin
        s_nxt.deb_cnt[k] = s_r.deb_cnt[k] + 2'h1;
      end
    end

    // calibration mode: remote requests override the software selection
    s_nxt.remote = 1'b1;
    if (s_r.level[REQ_ZERO]) begin
      s_nxt.cal = CAL_ZERO;
    end else if (s_r.level[REQ_SPAN]) begin
      s_nxt.cal = CAL_SPAN;
    end else if (s_r.level[REQ_MID]) begin
      s_nxt.cal = CAL_MID;
    end else begin
      s_nxt.cal    = rsc_cal_t'(s_r.ctrl[CTRL_CAL_LSB +: 2]);
      s_nxt.remote = 1'b0;
    end
    s_nxt.remote_ind[REQ_ZERO] = s_r.remote && (s_r.cal == CAL_ZERO);
    s_nxt.remote_ind[REQ_SPAN] = s_r.remote && (s_r.cal == CAL_SPAN);
    s_nxt.remote_ind[REQ_MID]  = s_r.remote && (s_r.cal == CAL_MID);

    // status outputs
    s_nxt.status[OUT_HEALTHY] = ~s_r.ctrl[CTRL_FAULT];
    s_nxt.status[OUT_VALID]   = s_r.ctrl[CTRL_VALID];
    s_nxt.status[OUT_UPPER]   = s_r.ctrl[CTRL_AUTO] & s_r.ctrl[CTRL_UPPER];
    s_nxt.status[OUT_LOWER]   = s_r.ctrl[CTRL_AUTO] & ~s_r.ctrl[CTRL_UPPER];
    s_nxt.status[OUT_ZERO]    = (s_r.cal == CAL_ZERO);
    s_nxt.status[OUT_SPAN]    = (s_r.cal == CAL_SPAN);
    s_nxt.status[OUT_SERVICE] = s_r.ctrl[CTRL_DIAG];
    s_nxt.status[OUT_SPARE]   = 1'b0;

    // apb: setup cycle latches the answer, access cycle presents it
    s_nxt.apb.pready  = 1'b0;
    s_nxt.apb.pslverr = 1'b0;
    if (i_apb.psel && !i_apb.penable) begin
      case (i_apb.paddr)
        ADDR_CTRL: begin
          rd[CTRL_W-1:0] = s_r.ctrl;
        end
        ADDR_STATUS: begin
          rd[ST_CAL_LSB +: 2] = s_r.cal;
          rd[ST_REMOTE]       = s_r.remote;
          rd[ST_INTER]        = (s_r.term == TM_INTERACTIVE);
          rd[ST_LIST_RUN]     = (s_r.list == LS_RUN);
          rd[ST_LIST_PS]      = (s_r.list == LS_PAUSED);
          rd[ST_CMD_PEND]     = s_r.cmd_pend;
          rd[ST_SW_BUSY]      = s_r.sw_pend;
          rd[ST_LEN_LSB +: 6] = s_r.len;
        end
        default: begin
          if (addr_mapped(i_apb.paddr) && (i_apb.paddr >= ADDR_LINE_BASE)) begin
            woff = i_apb.paddr - ADDR_LINE_BASE;
            for (int j = 0; j < 4; j++) begin
              rd[8*j +: 8] = s_r.line[{woff[4:2], 2'(j)}];
            end
          end
        end
      endcase
      s_nxt.apb.prdata  = rd;
      s_nxt.apb.pready  = 1'b1;
      s_nxt.apb.pslverr = ~addr_mapped(i_apb.paddr);
    end
    if (i_apb.psel && i_apb.penable && i_apb.pwrite && s_r.apb.pready) begin
      case (i_apb.paddr)
        ADDR_CTRL: begin
          s_nxt.ctrl = i_apb.pwdata[CTRL_W-1:0];
        end
        ADDR_CMD_ACK: begin
          if (i_apb.pwdata[0]) begin
            s_nxt.cmd_pend = 1'b0;
            s_nxt.len      = 6'h00;
          end
        end
        ADDR_TXDATA: begin
          if (!s_r.sw_pend) begin
            s_nxt.sw_byte = i_apb.pwdata[7:0];
            s_nxt.sw_eom  = i_apb.pwdata[TX_EOM_BIT];
            s_nxt.sw_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // transmit: cr lf, echo, software bytes, then the help listing
    if (s_r.tx.valid && i_tx_ready) begin
      s_nxt.tx.valid = 1'b0;
    end
    if (!s_r.tx.valid || i_tx_ready) begin
      if (s_r.pend_cr) begin
        s_nxt.tx      = '{valid: 1'b1, data: CH_CR};
        s_nxt.pend_cr = 1'b0;
      end else if (s_r.pend_lf) begin
        s_nxt.tx      = '{valid: 1'b1, data: CH_LF};
        s_nxt.pend_lf = 1'b0;
      end else if (s_r.echo_pend) begin
        s_nxt.tx        = '{valid: 1'b1, data: s_r.echo_byte};
        s_nxt.echo_pend = 1'b0;
      end else if (s_r.sw_pend) begin
        s_nxt.tx      = '{valid: 1'b1, data: s_r.sw_byte};
        s_nxt.sw_pend = 1'b0;
        s_nxt.pend_cr = s_r.sw_eom;
        s_nxt.pend_lf = s_r.sw_eom;
      end else if (s_r.list == LS_RUN) begin
        s_nxt.tx       = '{valid: 1'b1, data: help_byte(s_r.help_idx)};
        s_nxt.help_idx = s_r.help_idx + 7'h01;
        if (s_r.help_idx == HELP_LAST) begin
          s_nxt.list = LS_IDLE;
        end
      end
    end

    // receive and line editing
    flags_set = s_r.ctrl[CTRL_FLAG1] | s_r.ctrl[CTRL_FLAG2];
    if (i_rx.valid) begin
      b = i_rx.data;
      case (b)
        CH_CTRL_T: begin
          if (!flags_set) begin
            s_nxt.term = TM_INTERACTIVE;
          end
        end
        CH_CTRL_C: begin
          if (s_r.list == LS_RUN) begin
            s_nxt.list = LS_PAUSED;
          end else if (s_r.list == LS_IDLE) begin
            s_nxt.term = TM_COMPUTER;
          end
        end
        CH_CTRL_P: begin
          if (s_r.list == LS_PAUSED) begin
            s_nxt.list = LS_RUN;
          end
        end
        CH_CR: begin
          if (!s_r.cmd_pend && (s_r.list == LS_IDLE)) begin
            if ((s_r.len != 6'h00) && (s_r.line[0] == CH_QUERY) &&
                ((s_r.len == 6'h01) || (s_r.line[1] == CH_SPACE))) begin
              s_nxt.list     = LS_RUN;
              s_nxt.help_idx = 7'h00;
              s_nxt.len      = 6'h00;
            end else if (s_r.len != 6'h00) begin
              s_nxt.cmd_pend = 1'b1;
            end
            if (s_r.term == TM_INTERACTIVE) begin
              s_nxt.pend_cr = 1'b1;
              s_nxt.pend_lf = 1'b1;
            end
          end
        end
        CH_BS: begin
          if ((s_r.term == TM_INTERACTIVE) && !s_r.cmd_pend && (s_r.len != 6'h00)) begin
            s_nxt.len = s_r.len - 6'h01;
          end
        end
        CH_ESC: begin
          if ((s_r.term == TM_INTERACTIVE) && !s_r.cmd_pend) begin
            s_nxt.len = 6'h00;
          end
        end
        default: begin
          if (is_printable(b) && !s_r.cmd_pend && (s_r.len < LINE_MAX)) begin
            s_nxt.line[s_r.len[4:0]] = to_upper(b);
            s_nxt.len                = s_r.len + 6'h01;
          end
          if (is_printable(b) && (s_r.term == TM_INTERACTIVE)) begin
            s_nxt.echo_byte = b;
            s_nxt.echo_pend = 1'b1;
          end
        end
      endcase
    end
    if (flags_set) begin
      s_nxt.term = TM_COMPUTER;
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_apb                        = s_r.apb;
  assign o_tx                         = s_r.tx;
  assign o_status                     = s_r.status;
  assign o_remote_zero_indication     = s_r.remote_ind[REQ_ZERO];
  assign o_remote_span_indication     = s_r.remote_ind[REQ_SPAN];
  assign o_remote_midpoint_indication = s_r.remote_ind[REQ_MID];

endmodule

// file: rsc_remote_ctrl_sva.sv
// checker: port assertions for the remote status and terminal block
// assumes only the block's ports, attached by the bind at the foot
`timescale 1ns/1ps
module rsc_remote_ctrl_sva
  import rsc_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_rst_n,
  input wire rsc_apb_req_t i_apb,
  input wire rsc_apb_rsp_t o_apb,
  input wire logic [2:0]   i_remote_req,
  input wire logic [2:0]   i_remote_spare,
  input wire logic [7:0]   o_status,
  input wire logic         o_remote_zero_indication,
  input wire logic         o_remote_span_indication,
  input wire logic         o_remote_midpoint_indication,
  input wire rsc_byte_t    i_rx,
  input wire rsc_byte_t    o_tx,
  input wire logic         i_tx_ready
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // =====
  // sequences
  // =====
  sequence s_wr_ctrl;
    i_apb.psel && i_apb.penable && i_apb.pwrite && o_apb.pready && i_apb.paddr == ADDR_CTRL;
  endsequence
  sequence s_wr_done;
    s_wr_ctrl ##1 1'b1;
  endsequence
  sequence s_zero_on;
    i_remote_req[REQ_ZERO] [*8];
  endsequence
  sequence s_zero_off;
    !i_remote_req[REQ_ZERO] [*8];
  endsequence
  // =====
  // assertions
  // =====
  AST_HEALTHY: assert property (s_wr_done |=> o_status[OUT_HEALTHY] == !$past(i_apb.pwdata[CTRL_FAULT], 2))
    else $error("healthy output wrong");
  AST_VALID: assert property (s_wr_done |=> o_status[OUT_VALID] == $past(i_apb.pwdata[CTRL_VALID], 2))
    else $error("valid output wrong");
  AST_UPPER: assert property (s_wr_done |=> o_status[OUT_UPPER] == $past(i_apb.pwdata[3:2] == 2'h3, 2))
    else $error("upper scale output wrong");
  AST_SCALES: assert property (!(o_status[OUT_UPPER] && o_status[OUT_LOWER]))
    else $error("both scale outputs on");
  AST_SERVICE: assert property (s_wr_done |=> o_status[OUT_SERVICE] == $past(i_apb.pwdata[CTRL_DIAG], 2))
    else $error("service output wrong");
  AST_ZERO_IND: assert property (o_remote_zero_indication |-> o_status[OUT_ZERO] && !o_status[OUT_SPAN])
    else $error("zero indication without zero output");
  AST_SPAN_IND: assert property (o_remote_span_indication |-> o_status[OUT_SPAN] && !o_status[OUT_ZERO])
    else $error("span indication without span output");
  AST_MID_IND: assert property (o_remote_midpoint_indication |-> !o_status[OUT_ZERO] && !o_status[OUT_SPAN])
    else $error("midpoint indication with other cal output");
  AST_SPARE: assert property (!o_status[OUT_SPARE])
    else $error("spare output on");
  AST_DEB_ON: assert property (s_zero_on |=> ##[0:4] o_remote_zero_indication)
    else $error("held zero request not taken");
  AST_DEB_OFF: assert property (s_zero_off |=> ##2 !o_remote_zero_indication)
    else $error("released zero request still shown");
  AST_TX_HOLD: assert property (o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx.data))
    else $error("tx byte dropped before accept");
endmodule

bind rsc_remote_ctrl rsc_remote_ctrl_sva u_sva (
  .i_clk, .i_rst_n, .i_apb, .o_apb, .i_remote_req, .i_remote_spare, .o_status,
  .o_remote_zero_indication, .o_remote_span_indication, .o_remote_midpoint_indication,
  .i_rx, .o_tx, .i_tx_ready
);

// file: rsc_term_model.sv
// model: serial terminal, sends bytes and sinks what the block transmits
// assumes the byte strobe interface and one clock
`timescale 1ns/1ps
module rsc_term_model
  import rsc_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  input  wire rsc_byte_t i_tx,
  input  wire logic      i_slow,
  output logic           o_tx_ready = 1'h0,
  output rsc_byte_t      o_rx = '0
);
  logic [7:0] got_q[$];
  logic [1:0] ph_r = 2'h0;
  // =====
  // sink: prompt, or one byte in four
  // =====
  always @(posedge i_clk) begin
    ph_r <= ph_r + 2'h1;
    if (i_tx.valid && o_tx_ready) begin
      got_q.push_back(i_tx.data);
    end
    o_tx_ready <= i_rst_n && (!i_slow || ph_r == 2'h3);
  end
  // =====
  // sender: one strobe, data inverted when idle
  // =====
  task automatic send_str(input string s);
    foreach (s[i]) begin
      @(posedge i_clk);
      o_rx <= '{valid: 1'h1, data: s[i]};
      @(posedge i_clk);
      o_rx <= '{valid: 1'h0, data: ~s[i]};
    end
  endtask
endmodule

// file: rsc_remote_ctrl_tb_top.sv
// testbench: apb, remote request and terminal scenarios with self checks
// assumes the terminal model and the bound checker
`timescale 1ns/1ps
module rsc_remote_ctrl_tb_top
  import rsc_pkg::*;
;
  logic         i_clk = 1'h0;
  logic         i_rst_n = 1'h0;
  rsc_apb_req_t apb = '0;
  rsc_apb_rsp_t apb_rsp;
  logic [2:0]   req = 3'h0;
  logic [2:0]   spare = 3'h0;
  logic [7:0]   status;
  logic [2:0]   ind;
  rsc_byte_t    rx;
  rsc_byte_t    tx;
  logic         tx_ready;
  logic         slow = 1'h0;
  logic [31:0]  rd;
  logic         err;
  int           errors = 0;
  int           cmp_count = 0;
  int           cycles = 0;

  always #12.5 i_clk = ~i_clk;

  rsc_remote_ctrl DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_apb(apb), .o_apb(apb_rsp), .i_remote_req(req),
    .i_remote_spare(spare), .o_status(status), .o_remote_zero_indication(ind[0]),
    .o_remote_span_indication(ind[1]), .o_remote_midpoint_indication(ind[2]),
    .i_rx(rx), .o_tx(tx), .i_tx_ready(tx_ready)
  );
  rsc_term_model u_term (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx(tx), .i_slow(slow), .o_tx_ready(tx_ready), .o_rx(rx)
  );
  // =====
  // compare, bus cycle, verdict
  // =====
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    apb <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clk);
    apb.penable <= 1'h1;
    do begin
      @(posedge i_clk);
    end while (apb_rsp.pready !== 1'h1);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb <= '0;
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      $display("unexpected timeout");
      finish_test();
    end
  end
  // =====
  // scenarios
  // =====
  task automatic t_status();
    logic [16:0] tbl [5] = '{{9'h001, 8'h00}, {9'h00E, 8'h07}, {9'h036, 8'h6B}, {9'h044, 8'h51}, {9'h060, 8'h01}};
    foreach (tbl[i]) begin
      bus(1'h1, ADDR_CTRL, 32'(tbl[i][16:8]));
      repeat (3) @(posedge i_clk);
      chk("status outputs", 32'(tbl[i][7:0]), 32'(status));
    end
    bus(1'h0, 8'h30, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped read data", 32'h0, rd);
    bus(1'h1, ADDR_CTRL, 32'h0);
  endtask
  task automatic t_remote();
    int n;
    for (int k = 0; k < 3; k++) begin
      req <= 3'(1 << k);
      spare <= 3'h7;
      repeat (2) @(posedge i_clk);
      req <= 3'h0;
      repeat (12) @(posedge i_clk);
      chk("glitch indication", 32'h0, 32'(ind));
      req <= 3'(1 << k);
      n = 0;
      while (ind !== 3'(1 << k) && n < 40) begin
        @(posedge i_clk);
        n++;
      end
      chk("remote indication", 32'(1 << k), 32'(ind));
      chk("cal outputs", 32'(k < 2) << (k + 3), 32'(status[4:3]) << 3);
      bus(1'h0, ADDR_STATUS, 32'h0);
      chk("cal mode", 32'(4 + k + 1), 32'(rd[2:0]));
      req <= 3'h0;
      spare <= 3'h0;
      repeat (16) @(posedge i_clk);
      chk("released indication", 32'h0, 32'(ind | status[4:3]));
    end
  endtask
  task automatic t_term();
    u_term.send_str("a");
    repeat (4) @(posedge i_clk);
    chk("computer echo", 32'h0, 32'(u_term.got_q.size()));
    bus(1'h1, ADDR_CTRL, 32'h80);
    u_term.send_str("\024");
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("flag blocks terminal", 32'h0, 32'(rd[ST_INTER]));
    bus(1'h1, ADDR_CTRL, 32'h0);
    u_term.send_str("\024q");
    repeat (4) @(posedge i_clk);
    chk("echo", 32'h71, 32'(u_term.got_q[$]));
    u_term.send_str("\033ab\010c");
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("line before cr", 32'h2, 32'(rd[ST_LEN_LSB +: 6]));
    u_term.send_str("\015");
    repeat (6) @(posedge i_clk);
    chk("cr lf echo", 32'h0D0A, 32'({u_term.got_q[$-1], u_term.got_q[$]}));
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("pending", 32'h1, 32'(rd[ST_CMD_PEND]));
    bus(1'h0, ADDR_LINE_BASE, 32'h0);
    chk("line text", 32'h4341, 32'(rd[15:0]));
    bus(1'h1, ADDR_CMD_ACK, 32'h1);
    bus(1'h1, ADDR_TXDATA, 32'h141);
    repeat (6) @(posedge i_clk);
    chk("sw message", 32'h410D0A, 32'({u_term.got_q[$-2], u_term.got_q[$-1], u_term.got_q[$]}));
  endtask
  task automatic t_list();
    int n;
    slow <= 1'h1;
    u_term.send_str("?\015");
    repeat (40) @(posedge i_clk);
    u_term.send_str("\003");
    repeat (8) @(posedge i_clk);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("listing halted", 32'h1, 32'(rd[ST_LIST_PS]));
    n = u_term.got_q.size();
    u_term.send_str("\003");
    repeat (30) @(posedge i_clk);
    chk("halted output", 32'(n), 32'(u_term.got_q.size()));
    u_term.send_str("\020");
    n = 0;
    do begin
      bus(1'h0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[5:4] !== 2'h0 && n < 200);
    repeat (8) @(posedge i_clk);
    n = u_term.got_q.size() - HELP_LEN;
    for (int i = 0; i < HELP_LEN; i++) begin
      chk("listing byte", 32'(HELP_TEXT[8*(HELP_LEN-1-i) +: 8]), 32'(u_term.got_q[n+i]));
    end
    u_term.send_str("\003");
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("computer mode", 32'h0, 32'(rd[ST_INTER]));
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_clk);
    chk("reset status", 32'h01, 32'(status));
    t_status();
    t_remote();
    t_term();
    t_list();
    finish_test();
  end
endmodule
